// file: hw/rtcai_irq_timeouts.sv
// alarm compare, periodic, supply-fail and watchdog sources with apb registers
// assumes clock counters and a one-cycle update strobe from logic on clk
//
// The APB register port was decided locally.
`timescale 1ns/1ps
// What this block does
// - alarm bytes at indices 1,3,5,7
// - compare counters on each update strobe
// - full unmasked match sets alarm flag
// - alarm flag with enable drives interrupt
// - flags read clears alarm condition
// - mask bits 7 and 6 both set
// - mask patterns give second to monthly rates
// - interrupt released during battery backup
// - backup alarm enable keeps alarm interrupt
// - alarm enable cleared by power-on reset
// - supply fail sets flag, optional interrupt
// - cpu reset follows write-protect delay later
// - supply-fail enable cleared at power-up
// - battery checked at power-up into flag
// - dog select picks timeout and pulse
// - rate select zero off, else doubling
// - flags read clears alarm, periodic and supply-fail flags, releases interrupt
// - periodic flag at rate, optional interrupt
// - missed toggle pulses reset, holds expired
module rtcai_irq_timeouts
	import rtcai_pkg::*;
#(
	parameter int DOG_TICKS = DOG_BASE_TICKS,
	parameter int DOG_RST_TICKS = DOG_RST_BASE_TICKS,
	parameter int WPT_CYCLES = WPT_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] curSeconds,
	input wire logic [7:0] curMinutes,
	input wire logic [7:0] curHours,
	input wire logic [7:0] curDate,
	input wire logic updateStrobe,
	input wire logic oscIn,
	input wire logic dogIn,
	input wire logic supplyFail,
	input wire logic backupMode,
	input wire logic batteryLow,
	output logic irqOut,
	output logic irqOe_n,
	output logic cpuRstOut,
	output logic cpuRstOe_n,
	output logic dogExpiredOut_n
);
	logic [4:0] pinRaw;
	logic [4:0] pinQ;
	logic oscPrev_q, dogPrev_q, pfPrev_q;
	logic oscRise, dogEdge, pfRise, inBackup;
	logic [7:0] alarm_q [4];
	logic [7:0] curVal [4];
	logic [3:0] byteHit;
	logic alarmHit;
	logic [3:0] intctl_q;
	logic [6:0] rate_q;
	logic [3:0] flags_q;
	logic [3:0] clrMask;
	logic [3:0] rateSel;
	logic [2:0] dogSel;
	logic [13:0] perCnt_q, perLimit;
	logic perHit;
	logic [31:0] wptCnt_q;
	logic pfReset_q;
	logic [2:0] startCnt_q;
	rtcai_dog_type dogState_q;
	logic [16:0] dogCnt_q, dogLimit, pulseLimit;
	logic dogEn;
	logic irqIdle_q, rstIdle_q, dogOk_q;
	logic [3:0] idx;
	logic mapped, isFlagsRd, access, done;
	logic [2:0] holdCnt_q;
	logic pready_q, pready_d, pslverr_q;
	logic [31:0] prdata_q, rdVal;

	// pins from outside pass three flops; a change counts when the last two agree
	assign pinRaw = {batteryLow, backupMode, supplyFail, dogIn, oscIn};
	for (genvar g = 0; g < 5; g++) begin : g_sync
		logic s1, s2, s3, q;
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				s1 <= 1'b0;
				s2 <= 1'b0;
				s3 <= 1'b0;
				q <= 1'b0;
			end else begin
				s1 <= pinRaw[g];
				s2 <= s1;
				s3 <= s2;
				if (s2 == s3) begin
					q <= s3;
				end
			end
		end
		assign pinQ[g] = q;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			oscPrev_q <= 1'b0;
			dogPrev_q <= 1'b0;
			pfPrev_q <= 1'b0;
		end else begin
			oscPrev_q <= pinQ[0];
			dogPrev_q <= pinQ[1];
			pfPrev_q <= pinQ[2];
		end
	end
	assign oscRise = pinQ[0] & ~oscPrev_q;
	assign dogEdge = pinQ[1] ^ dogPrev_q;
	assign pfRise = pinQ[2] & ~pfPrev_q;
	assign inBackup = pinQ[3];

	// alarm compare, one byte per lane
	assign curVal[0] = curSeconds;
	assign curVal[1] = curMinutes;
	assign curVal[2] = curHours;
	assign curVal[3] = curDate;
	for (genvar b = 0; b < 4; b++) begin : g_cmp
		assign byteHit[b] = (alarm_q[b][ALARM_MASK_HI] & alarm_q[b][ALARM_MASK_LO])
			| (alarm_q[b] == curVal[b]);
	end
	assign alarmHit = updateStrobe & (&byteHit);

	// periodic divider on oscillator ticks
	assign rateSel = rate_q[RATE_SEL_LSB +: 4];
	assign dogSel = rate_q[DOG_SEL_LSB +: 3];
	assign perLimit = (rateSel == 4'h0) ? 14'h0000 : 14'((15'h0001 << (rateSel - 4'h1)) - 15'h0001);
	assign perHit = oscRise & (rateSel != 4'h0) & (perCnt_q == perLimit);
	always_ff @(posedge clk) begin
		if (!rst_n || rateSel == 4'h0) begin
			perCnt_q <= 14'h0000;
		end else if (oscRise) begin
			perCnt_q <= perHit ? 14'h0000 : perCnt_q + 14'h0001;
		end
	end

	// cpu reset trails the supply-fail interrupt by the write-protect delay
	always_ff @(posedge clk) begin
		if (!rst_n || !pinQ[2]) begin
			wptCnt_q <= 32'h0;
			pfReset_q <= 1'b0;
		end else if (wptCnt_q == 32'(WPT_CYCLES)) begin
			pfReset_q <= 1'b1;
		end else begin
			wptCnt_q <= wptCnt_q + 32'h1;
		end
	end

	// watchdog periods; 000 and 111 are the long settings
	always_comb begin
		unique case (dogSel)
			3'b000: begin
				dogLimit = 17'(DOG_TICKS << DOG_DEF_SHIFT);
				pulseLimit = 17'(DOG_RST_TICKS << DOG_DEF_SHIFT);
			end
			3'b111: begin
				dogLimit = 17'(DOG_TICKS << DOG_LONG_SHIFT);
				pulseLimit = 17'(DOG_RST_TICKS << DOG_LONG_SHIFT);
			end
			default: begin
				dogLimit = 17'(DOG_TICKS << (dogSel - 3'h1));
				pulseLimit = 17'(DOG_RST_TICKS << (dogSel - 3'h1));
			end
		endcase
	end
	assign dogEn = ~inBackup & ~pinQ[2];

	always_ff @(posedge clk) begin
		if (!rst_n || !dogEn) begin
			dogState_q <= DOG_WATCH;
			dogCnt_q <= 17'h0;
			dogOk_q <= 1'b1;
		end else begin
			if (dogEdge) begin
				dogOk_q <= 1'b1;
			end
			unique case (dogState_q)
				DOG_WATCH: begin
					if (dogEdge) begin
						dogCnt_q <= 17'h0;
					end else if (oscRise) begin
						// at or past the limit, so a shorter setting cannot let the count run on
						if (dogCnt_q >= dogLimit - 17'h1) begin
							dogState_q <= DOG_PULSE;
							dogCnt_q <= 17'h0;
							dogOk_q <= 1'b0;
						end else begin
							dogCnt_q <= dogCnt_q + 17'h1;
						end
					end
				end
				DOG_PULSE: begin
					if (oscRise) begin
						if (dogCnt_q >= pulseLimit - 17'h1) begin
							dogState_q <= DOG_WATCH;
							dogCnt_q <= 17'h0;
						end else begin
							dogCnt_q <= dogCnt_q + 17'h1;
						end
					end
				end
			endcase
		end
	end

	// apb slave: one wait state, flags reads wait for the address hold
	assign idx = paddr[5:2];
	assign mapped = (paddr[1:0] == 2'b00) & (idx == IDX_ALM_SEC | idx == IDX_ALM_MIN | idx == IDX_ALM_HR
		| idx == IDX_ALM_DATE | idx == IDX_RATE | idx == IDX_INTCTL | idx == IDX_FLAGS);
	assign isFlagsRd = mapped & ~pwrite & (idx == IDX_FLAGS);
	assign access = psel & penable;
	assign done = access & pready_q;
	assign pready_d = access & ~pready_q & (~isFlagsRd | holdCnt_q >= FLAGS_HOLD_CYC - 3'h1);

	always_comb begin
		rdVal = 32'h0;
		unique case (idx)
			IDX_ALM_SEC: rdVal[7:0] = alarm_q[0];
			IDX_ALM_MIN: rdVal[7:0] = alarm_q[1];
			IDX_ALM_HR: rdVal[7:0] = alarm_q[2];
			IDX_ALM_DATE: rdVal[7:0] = alarm_q[3];
			IDX_RATE: rdVal[6:0] = rate_q;
			IDX_INTCTL: rdVal[3:0] = intctl_q;
			IDX_FLAGS: rdVal[3:0] = flags_q;
			default: rdVal = 32'h0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !psel || done || !isFlagsRd) begin
			holdCnt_q <= 3'h0;
		end else if (holdCnt_q != 3'h7) begin
			holdCnt_q <= holdCnt_q + 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= pready_d;
			if (pready_d) begin
				pslverr_q <= ~mapped;
				prdata_q <= (mapped & ~pwrite) ? rdVal : 32'h0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				alarm_q[i] <= ALM_RST;
			end
			intctl_q <= INTCTL_RST;
			rate_q <= RATE_RST;
		end else if (done && pwrite && mapped) begin
			unique case (idx)
				IDX_ALM_SEC: alarm_q[0] <= pwdata[7:0];
				IDX_ALM_MIN: alarm_q[1] <= pwdata[7:0];
				IDX_ALM_HR: alarm_q[2] <= pwdata[7:0];
				IDX_ALM_DATE: alarm_q[3] <= pwdata[7:0];
				IDX_RATE: rate_q <= pwdata[6:0];
				IDX_INTCTL: intctl_q <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	// only flags the host actually saw are cleared; a new event wins
	assign clrMask = (done && isFlagsRd) ? (prdata_q[3:0] & 4'b0111) : 4'h0;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flags_q <= 4'(1 << BATTERY_VALID_FLAG);
			startCnt_q <= 3'h0;
		end else begin
			flags_q[ALARM_FLAG] <= (flags_q[ALARM_FLAG] & ~clrMask[ALARM_FLAG]) | alarmHit;
			flags_q[PERIODIC_FLAG] <= (flags_q[PERIODIC_FLAG] & ~clrMask[PERIODIC_FLAG]) | perHit;
			flags_q[SUPPLY_FAIL_FLAG] <= (flags_q[SUPPLY_FAIL_FLAG] & ~clrMask[SUPPLY_FAIL_FLAG]) | pfRise;
			// synchronisers are cleared by reset too; read the battery pin once they have refilled
			if (startCnt_q != BVF_SETTLE + 3'h1) begin
				startCnt_q <= startCnt_q + 3'h1;
				if (startCnt_q == BVF_SETTLE) begin
					flags_q[BATTERY_VALID_FLAG] <= ~pinQ[4];
				end
			end
		end
	end

	// outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irqIdle_q <= 1'b1;
			rstIdle_q <= 1'b1;
		end else begin
			if (inBackup) begin
				irqIdle_q <= ~(intctl_q[ALARM_IN_BACKUP_ENABLE] & intctl_q[ALARM_IRQ_ENABLE]
					& flags_q[ALARM_FLAG]);
			end else begin
				irqIdle_q <= ~((flags_q[ALARM_FLAG] & intctl_q[ALARM_IRQ_ENABLE])
					| (flags_q[PERIODIC_FLAG] & intctl_q[PERIODIC_IRQ_ENABLE])
					| (flags_q[SUPPLY_FAIL_FLAG] & intctl_q[SUPPLY_FAIL_IRQ_ENABLE]));
			end
			rstIdle_q <= ~(pfReset_q | (dogState_q == DOG_PULSE));
		end
	end
	assign irqOut = 1'b0;
	assign irqOe_n = irqIdle_q;
	assign cpuRstOut = 1'b0;
	assign cpuRstOe_n = rstIdle_q;
	assign dogExpiredOut_n = dogOk_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_alarm_sets_flag: assert property (alarmHit |=> flags_q[ALARM_FLAG])
		else $error("alarm match did not set flag");
	a_alarm_every_second: assert property (updateStrobe && (&{alarm_q[0][7:6], alarm_q[1][7:6],
		alarm_q[2][7:6], alarm_q[3][7:6]}) |=> flags_q[ALARM_FLAG])
		else $error("fully masked alarm missed");
	a_mask_bits_match: assert property (updateStrobe && alarm_q[3][7:6] == 2'b11 && alarm_q[0] == curSeconds
		&& alarm_q[1] == curMinutes && alarm_q[2] == curHours |=> flags_q[ALARM_FLAG])
		else $error("masked byte failed to match");
	a_alarm_irq_drive: assert property (flags_q[ALARM_FLAG] && intctl_q[ALARM_IRQ_ENABLE] && !inBackup
		|=> !irqOe_n)
		else $error("alarm interrupt not driven");
	a_backup_release: assert property (inBackup && !intctl_q[ALARM_IN_BACKUP_ENABLE] |=> irqOe_n)
		else $error("interrupt driven in backup");
	a_read_clears_flag: assert property (done && isFlagsRd && prdata_q[ALARM_FLAG] && !alarmHit
		|=> !flags_q[ALARM_FLAG])
		else $error("flags read did not clear alarm");
	a_enables_at_reset: assert property ($rose(rst_n) |-> intctl_q == INTCTL_RST)
		else $error("enables not cleared by reset");
	a_supply_fail_flag: assert property (pfRise |=> flags_q[SUPPLY_FAIL_FLAG] ##1 !pfReset_q)
		else $error("supply fail flag late");
	a_reset_after_delay: assert property (pfRise |=> !pfReset_q [*8])
		else $error("cpu reset ahead of delay");
	a_flags_hold: assert property (done && isFlagsRd |-> $past(psel, 4))
		else $error("flags cleared without address hold");
	a_periodic_flag: assert property (perHit |=> flags_q[PERIODIC_FLAG])
		else $error("periodic flag missed");
	a_dog_pulse_reset: assert property (dogState_q == DOG_PULSE |=> !cpuRstOe_n)
		else $error("watchdog pulse without reset");
	c_alarm_irq: cover property (alarmHit && intctl_q[ALARM_IRQ_ENABLE] ##1 1'b1 ##1 !irqOe_n);
	c_periodic: cover property (perHit ##2 !irqOe_n);
	c_dog_expiry: cover property ($fell(dogExpiredOut_n));
	c_flags_read: cover property (done && isFlagsRd && prdata_q[3:0] != 4'h0);
endmodule : rtcai_irq_timeouts

// file: hw/rtcai_pkg.sv
// constants for the rtc alarm, periodic, supply-fail and watchdog logic
// assumes a 100 MHz clk and a 32.768 kHz oscillator level on a pin
package rtcai_pkg;
	localparam int ADDR_W = 6;
	// register indices; byte address is four times the index
	localparam logic [3:0] IDX_ALM_SEC = 4'h1;
	localparam logic [3:0] IDX_ALM_MIN = 4'h3;
	localparam logic [3:0] IDX_ALM_HR = 4'h5;
	localparam logic [3:0] IDX_ALM_DATE = 4'h7;
	localparam logic [3:0] IDX_RATE = 4'hb;
	localparam logic [3:0] IDX_INTCTL = 4'hc;
	localparam logic [3:0] IDX_FLAGS = 4'hd;
	// intctl fields
	localparam int ALARM_IRQ_ENABLE = 0;
	localparam int PERIODIC_IRQ_ENABLE = 1;
	localparam int SUPPLY_FAIL_IRQ_ENABLE = 2;
	localparam int ALARM_IN_BACKUP_ENABLE = 3;
	// flags fields
	localparam int ALARM_FLAG = 0;
	localparam int PERIODIC_FLAG = 1;
	localparam int SUPPLY_FAIL_FLAG = 2;
	localparam int BATTERY_VALID_FLAG = 3;
	// rate fields: rate select [3:0], dog period select [6:4]
	localparam int RATE_SEL_LSB = 0;
	localparam int DOG_SEL_LSB = 4;
	localparam int ALARM_MASK_HI = 7;
	localparam int ALARM_MASK_LO = 6;
	localparam logic [7:0] ALM_RST = 8'h00;
	localparam logic [3:0] INTCTL_RST = 4'h0;
	localparam logic [6:0] RATE_RST = 7'h00;
	// timing
	localparam longint CLK_PERIOD_NS = 10;
	localparam longint FLAGS_HOLD_NS = 50;
	localparam logic [2:0] FLAGS_HOLD_CYC = 3'((FLAGS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam longint OSC_HZ = 32768;
	localparam longint DOG_BASE_NS = 23437500;
	localparam longint DOG_RST_BASE_NS = 3906250;
	localparam int DOG_BASE_TICKS = int'(DOG_BASE_NS * OSC_HZ / 64'd1000000000);
	localparam int DOG_RST_BASE_TICKS = int'(DOG_RST_BASE_NS * OSC_HZ / 64'd1000000000);
	localparam int DOG_DEF_SHIFT = 6;
	localparam int DOG_LONG_SHIFT = 7;
	localparam int WPT_CYCLES_DEF = 16;
	localparam logic [2:0] BVF_SETTLE = 3'h4;
	typedef enum logic {DOG_WATCH, DOG_PULSE} rtcai_dog_type;
endpackage : rtcai_pkg

// file: verification/rtcai_host_model.sv
// host side of the block: pull-ups on the open-drain lines, watchdog kicker
// assumes an enable is low while the block pulls its line down
`timescale 1ns/1ps
module rtcai_host_model (
	input wire logic clk,
	input wire logic irqOut,
	input wire logic irqOe_n,
	input wire logic cpuRstOut,
	input wire logic cpuRstOe_n,
	input wire logic kickEn,
	output logic irqLine_n,
	output logic rstLine_n,
	output logic dogIn
);
	int cnt = 0;
	// released line floats up through the pull-up
	assign irqLine_n = irqOe_n ? 1'b1 : irqOut;
	assign rstLine_n = cpuRstOe_n ? 1'b1 : cpuRstOut;
	initial dogIn = 1'b0;
	always @(posedge clk) begin
		cnt <= cnt + 1;
		// toggles well inside the shortest timeout used
		if (kickEn && cnt % 40 == 0) begin
			dogIn <= ~dogIn;
		end
	end
endmodule : rtcai_host_model

// file: verification/tb_rtc_alarm_irq_and_timeouts.sv
// self-checking bench for the interrupt and timeout block
// assumes design counts shortened by parameters; oscillator scaled to 200 ns
`timescale 1ns/1ps
module tb_rtc_alarm_irq_and_timeouts;
	import rtcai_pkg::*;
	localparam int WPT = 8;
	logic clk, rst_n, psel, penable, pwrite, updateStrobe, oscIn, supplyFail, backupMode, batteryLow, kickEn;
	logic [5:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, errSeen, irqOut, irqOe_n, cpuRstOut, cpuRstOe_n, dogExpiredOut_n;
	logic irqLine_n, rstLine_n, dogIn;
	logic [7:0] cnt [4];
	logic [7:0] vals [4] = '{8'h30, 8'h15, 8'h12, 8'h07};
	logic [3:0] idxs [4] = '{IDX_ALM_SEC, IDX_ALM_MIN, IDX_ALM_HR, IDX_ALM_DATE};
	int fails = 0;
	int compares = 0;
	int cycles = 0;
	rtcai_irq_timeouts #(.DOG_TICKS(4), .DOG_RST_TICKS(2), .WPT_CYCLES(WPT)) uut (.clk(clk), .rst_n(rst_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .curSeconds(cnt[0]), .curMinutes(cnt[1]), .curHours(cnt[2]),
		.curDate(cnt[3]), .updateStrobe(updateStrobe), .oscIn(oscIn), .dogIn(dogIn), .supplyFail(supplyFail),
		.backupMode(backupMode), .batteryLow(batteryLow), .irqOut(irqOut), .irqOe_n(irqOe_n),
		.cpuRstOut(cpuRstOut), .cpuRstOe_n(cpuRstOe_n), .dogExpiredOut_n(dogExpiredOut_n));
	rtcai_host_model host (.clk(clk), .irqOut(irqOut), .irqOe_n(irqOe_n), .cpuRstOut(cpuRstOut),
		.cpuRstOe_n(cpuRstOe_n), .kickEn(kickEn), .irqLine_n(irqLine_n), .rstLine_n(rstLine_n), .dogIn(dogIn));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		oscIn = 1'b0;
		forever #100 oscIn = ~oscIn;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fails++;
			test_done();
		end
	end
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	task apb(input logic w, input logic [3:0] idx, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// address held until the slave answers
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task upd();
		@(posedge clk);
		updateStrobe <= 1'b1;
		@(posedge clk);
		updateStrobe <= 1'b0;
		wt(4);
	endtask : upd
	task t_reset();
		apb(0, IDX_FLAGS, 0);
		chk("flags", rd, 32'h8);
		apb(0, IDX_INTCTL, 0);
		chk("intctl", rd, 32'h0);
		apb(0, 4'h2, 0);
		chk("pslverr", errSeen, 1);
		$display("reset test done");
	endtask : t_reset
	task t_alarm();
		for (int m = 0; m <= 4; m++) begin
			for (int b = 0; b < 4; b++) begin
				apb(1, idxs[b], b < m ? vals[b] : 8'hc0);
				cnt[b] <= b == m ? vals[b] + 8'h1 : vals[b];
			end
			if (m > 0) begin
				cnt[m-1] <= vals[m-1] + 8'h1;
				upd();
				chk("noMatchIrq", irqLine_n, 1);
				@(posedge clk);
				cnt[m-1] <= vals[m-1];
			end
			upd();
			chk("matchIrq", irqLine_n, m == 0);
			apb(0, IDX_FLAGS, 0);
			chk("alarmFlags", rd, 32'h9);
			wt(2);
			chk("irqReleased", irqLine_n, 1);
			if (m == 0) begin
				apb(1, IDX_INTCTL, 32'h1);
			end
		end
		apb(0, IDX_ALM_DATE, 0);
		chk("almDate", rd, 32'h07);
		$display("alarm test done");
	endtask : t_alarm
	task t_backup();
		apb(1, IDX_ALM_DATE, 8'hc0);
		backupMode <= 1'b1;
		wt(5);
		upd();
		chk("backupIrq", irqLine_n, 1);
		apb(0, IDX_FLAGS, 0);
		chk("backupFlags", rd, 32'h9);
		apb(1, IDX_INTCTL, 32'h9);
		upd();
		chk("backupAlarmIrq", irqLine_n, 0);
		apb(1, IDX_INTCTL, 32'h0);
		apb(0, IDX_FLAGS, 0);
		backupMode <= 1'b0;
		wt(5);
		$display("backup test done");
	endtask : t_backup
	task t_periodic();
		apb(1, IDX_INTCTL, 32'h2);
		wt(100);
		apb(0, IDX_FLAGS, 0);
		chk("rateOffFlags", rd, 32'h8);
		apb(1, IDX_RATE, 32'h1);
		wt(60);
		chk("periodicIrq", irqLine_n, 0);
		apb(1, IDX_RATE, 32'h0);
		apb(0, IDX_FLAGS, 0);
		chk("periodicFlags", rd, 32'ha);
		apb(1, IDX_INTCTL, 32'h0);
		$display("periodic test done");
	endtask : t_periodic
	task t_dog();
		int n;
		n = 0;
		apb(1, IDX_RATE, 32'h10);
		kickEn <= 1'b0;
		while (dogExpiredOut_n !== 1'b0 && n < 400) begin
			wt(1);
			n++;
		end
		// code one is four ticks of 20 cycles less the last kick's age
		chk("dogTime", n >= 30 && n < 150, 1);
		wt(3);
		chk("dogRst", rstLine_n, 0);
		kickEn <= 1'b1;
		wt(100);
		chk("dogRecovered", dogExpiredOut_n, 1);
		$display("watchdog test done");
	endtask : t_dog
	task t_supply();
		int n;
		n = 0;
		apb(1, IDX_INTCTL, 32'h4);
		supplyFail <= 1'b1;
		while (irqLine_n !== 1'b0 && n < 20) begin
			wt(1);
			n++;
		end
		chk("supplyIrq", irqLine_n, 0);
		chk("rstAfterIrq", rstLine_n, 1);
		wt(WPT + 3);
		chk("supplyRst", rstLine_n, 0);
		@(posedge clk);
		supplyFail <= 1'b0;
		wt(8);
		apb(0, IDX_FLAGS, 0);
		chk("supplyFlags", rd, 32'hc);
		wt(2);
		chk("supplyCleared", irqLine_n, 1);
		@(posedge clk);
		batteryLow <= 1'b1;
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		apb(0, IDX_INTCTL, 0);
		chk("intctlAfterReset", rd, 32'h0);
		apb(0, IDX_FLAGS, 0);
		chk("batteryFlag", rd, 32'h0);
		$display("supply test done");
	endtask : t_supply
	task test_done();
		$display("checks %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done
	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, updateStrobe, supplyFail, backupMode, batteryLow} = '0;
		kickEn = 1'b1;
		paddr = '0;
		pwdata = '0;
		cnt = '{8'h0, 8'h0, 8'h0, 8'h0};
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_alarm();
		t_backup();
		t_periodic();
		t_dog();
		t_supply();
		test_done();
	end
endmodule : tb_rtc_alarm_irq_and_timeouts
